// ==== hdl/compare_input_source_select.sv ====
`timescale 1ns/1ps
`include "cmp_sel_cfg.svh"


module compare_input_source_select #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    // AXI4-Lite write address
    input  wire logic [ADDR_WIDTH-1:0]        s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_WIDTH-1:0]        s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Trip and comparator sources
    input  wire logic                         trip_input_one,
    input  wire logic                         trip_input_two,
    input  wire logic                         trip_input_three,
    input  wire logic                         comparator_one_output,
    input  wire logic                         comparator_two_output,
    input  wire logic                         comparator_three_output,
    // Selected compare inputs and qualified events
    output cmp_sel_pkg::compare_inputs_t      compare_inputs,
    output cmp_sel_pkg::events_t              compare_events
);

    logic [15:0]                  sel_reg;
    logic [11:0]                  qual_reg;
    logic                         aw_held_reg;
    logic                         w_held_reg;
    logic [ADDR_WIDTH-1:0]        awaddr_reg;
    logic [31:0]                  wdata_reg;
    logic [3:0]                   wstrb_reg;
    logic                         bvalid_reg;
    logic [1:0]                   bresp_reg;
    logic                         rvalid_reg;
    logic [1:0]                   rresp_reg;
    logic [31:0]                  rdata_reg;
    cmp_sel_pkg::compare_inputs_t cmp_reg;
    cmp_sel_pkg::events_t         evt_reg;
    cmp_sel_pkg::sources_t        src;
    logic [3:0]                   mux_out;
    logic                         wr_fire;
    logic                         wr_sel;
    logic                         wr_qual;
    logic                         rd_fire;
    logic                         wrote_sel_reg;

    // Write channel: address and data taken independently
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_sel        = wr_fire && (awaddr_reg == `CSS_SEL_OFFSET);
    assign wr_qual       = wr_fire && (awaddr_reg == `CSS_QUAL_OFFSET);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Unmapped or read-only addresses answer with an error
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `CSS_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_sel || wr_qual) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Fields store any code; reserved ones are software's to avoid
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= `CSS_SEL_RESET;
        end else if (wr_sel) begin
            if (wstrb_reg[0]) begin
                sel_reg[7:0] <= wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
                sel_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            qual_reg <= `CSS_QUAL_RESET;
        end else if (wr_qual) begin
            if (wstrb_reg[0]) begin
                qual_reg[7:0] <= wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
                qual_reg[11:8] <= wdata_reg[11:8];
            end
        end
    end

    // Read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_reg;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `CSS_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `CSS_RESP_OKAY;
            case (s_axi_araddr)
                `CSS_SEL_OFFSET:    rdata_reg <= {16'h0000, sel_reg};
                `CSS_QUAL_OFFSET:   rdata_reg <= {20'h00000, qual_reg};
                `CSS_STATUS_OFFSET: rdata_reg <= {24'h000000, evt_reg, cmp_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= `CSS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Trip inputs enter as raw levels, with no latch in front
    assign src.trip = {trip_input_three, trip_input_two, trip_input_one};
    assign src.comp = {comparator_three_output, comparator_two_output,
                       comparator_one_output};

    // Field i feeds compare input i: A high, A low, B high, B low
    for (genvar i = 0; i < 4; i++) begin : g_route
        source_mux u_mux (
            .sel (sel_reg[i*`CSS_FIELD_WIDTH +: `CSS_FIELD_WIDTH]),
            .src (src),
            .out (mux_out[i])
        );
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_reg <= '0;
        end else begin
            cmp_reg <= mux_out;
        end
    end

    assign compare_inputs = cmp_reg;

    function automatic logic qualify(input logic [2:0] code, input logic hi, input logic lo);
        case (code)
            `CSS_QUAL_HIGH_LOW:   qualify = !hi;
            `CSS_QUAL_HIGH_HIGH:  qualify = hi;
            `CSS_QUAL_LOW_LOW:    qualify = !lo;
            `CSS_QUAL_LOW_HIGH:   qualify = lo;
            `CSS_QUAL_LOW_NOT_HI: qualify = lo && !hi;
            default:              qualify = 1'b0;
        endcase
    endfunction : qualify

    // Registered so events never glitch on a source change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg <= '0;
        end else begin
            evt_reg.a_one <= qualify(qual_reg[`CSS_A_ONE_LSB +: `CSS_QUAL_WIDTH],
                                     cmp_reg.a_high, cmp_reg.a_low);
            evt_reg.a_two <= qualify(qual_reg[`CSS_A_TWO_LSB +: `CSS_QUAL_WIDTH],
                                     cmp_reg.a_high, cmp_reg.a_low);
            evt_reg.b_one <= qualify(qual_reg[`CSS_B_ONE_LSB +: `CSS_QUAL_WIDTH],
                                     cmp_reg.b_high, cmp_reg.b_low);
            evt_reg.b_two <= qualify(qual_reg[`CSS_B_TWO_LSB +: `CSS_QUAL_WIDTH],
                                     cmp_reg.b_high, cmp_reg.b_low);
        end
    end

    assign compare_events = evt_reg;

    // Checks only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrote_sel_reg <= 1'b0;
        end else if (wr_sel) begin
            wrote_sel_reg <= 1'b1;
        end
    end

    a_b_low_route: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(sel_reg[`CSS_B_LOW_LSB +: 4]) == `CSS_CODE_TRIP_TWO
            |-> cmp_reg.b_low == $past(trip_input_two))
        else $error("B low input does not follow trip input two");

    a_b_high_route: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(sel_reg[`CSS_B_HIGH_LSB +: 4]) == `CSS_CODE_COMP_ONE
            |-> cmp_reg.b_high == $past(comparator_one_output))
        else $error("B high input does not follow comparator one");

    a_a_low_route: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(sel_reg[`CSS_A_LOW_LSB +: 4]) == `CSS_CODE_TRIP_THREE
            |-> cmp_reg.a_low == $past(trip_input_three))
        else $error("A low input does not follow trip input three");

    a_a_high_route: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        // Flops still sit in reset at the release edge
        $past(rst_n) && $past(sel_reg[`CSS_A_HIGH_LSB +: 4]) == `CSS_CODE_TRIP_ONE
            |-> cmp_reg.a_high == $past(trip_input_one))
        else $error("A high input does not follow trip input one");

    a_comp_two_code: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(sel_reg[`CSS_B_LOW_LSB +: 4]) == `CSS_CODE_COMP_TWO
            |-> cmp_reg.b_low == $past(comparator_two_output))
        else $error("Code 9 does not select comparator two");

    a_trip_level: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ($past(sel_reg[`CSS_A_HIGH_LSB +: 4]) == `CSS_CODE_TRIP_ONE && $rose(cmp_reg.a_high))
            ##1 (sel_reg[3:0] == `CSS_CODE_TRIP_ONE && !trip_input_one)
            |=> !cmp_reg.a_high)
        else $error("Trip input held like a latch");

    a_event_window: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(qual_reg[`CSS_A_ONE_LSB +: 3]) == `CSS_QUAL_LOW_NOT_HI
            |-> evt_reg.a_one == ($past(cmp_reg.a_low) && !$past(cmp_reg.a_high)))
        else $error("Event code 101 misqualified");

    a_event_off: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(qual_reg[`CSS_B_TWO_LSB +: 3]) == `CSS_QUAL_OFF |-> !evt_reg.b_two)
        else $error("Disabled event fired");

    a_comp_three_code: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(sel_reg[`CSS_B_HIGH_LSB +: 4]) == `CSS_CODE_COMP_THREE
            |-> cmp_reg.b_high == $past(comparator_three_output))
        else $error("Code 1010 does not select comparator three");

    a_sel_reset: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !wrote_sel_reg |-> (sel_reg == 16'h0000 && !$past(wr_sel)))
        else $error("Select register not zero before first write");

    a_write_resp_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("Write response dropped before bready");

endmodule : compare_input_source_select

// ==== common/cmp_sel_cfg.svh ====
`ifndef CMP_SEL_CFG_SVH
`define CMP_SEL_CFG_SVH

// Register byte offsets
`define CSS_SEL_OFFSET      8'h00
`define CSS_QUAL_OFFSET     8'h04
`define CSS_STATUS_OFFSET   8'h08

// Reset values
`define CSS_SEL_RESET       16'h0000
`define CSS_QUAL_RESET      12'h000

// Selection field layout
`define CSS_FIELD_WIDTH     4
`define CSS_A_HIGH_LSB      0
`define CSS_A_LOW_LSB       4
`define CSS_B_HIGH_LSB      8
`define CSS_B_LOW_LSB       12

// Source codes
`define CSS_CODE_TRIP_ONE   4'h0
`define CSS_CODE_TRIP_TWO   4'h1
`define CSS_CODE_TRIP_THREE 4'h2
`define CSS_CODE_COMP_ONE   4'h8
`define CSS_CODE_COMP_TWO   4'h9
`define CSS_CODE_COMP_THREE 4'hA

// Qualification field layout
`define CSS_QUAL_WIDTH      3
`define CSS_A_ONE_LSB       0
`define CSS_A_TWO_LSB       3
`define CSS_B_ONE_LSB       6
`define CSS_B_TWO_LSB       9

// Qualification codes
`define CSS_QUAL_OFF        3'h0
`define CSS_QUAL_HIGH_LOW   3'h1
`define CSS_QUAL_HIGH_HIGH  3'h2
`define CSS_QUAL_LOW_LOW    3'h3
`define CSS_QUAL_LOW_HIGH   3'h4
`define CSS_QUAL_LOW_NOT_HI 3'h5

// Bus responses
`define CSS_RESP_OKAY       2'h0
`define CSS_RESP_SLVERR     2'h2

`endif

// ==== common/cmp_sel_pkg.sv ====
package cmp_sel_pkg;

    typedef struct packed {
        logic [2:0] comp;
        logic [2:0] trip;
    } sources_t;

    typedef struct packed {
        logic b_low;
        logic b_high;
        logic a_low;
        logic a_high;
    } compare_inputs_t;

    typedef struct packed {
        logic b_two;
        logic b_one;
        logic a_two;
        logic a_one;
    } events_t;

endpackage : cmp_sel_pkg

// ==== hdl/source_mux.sv ====
`timescale 1ns/1ps
`include "cmp_sel_cfg.svh"

module source_mux (
    // Selection
    input  wire logic [3:0]           sel,
    input  wire cmp_sel_pkg::sources_t src,
    // Result
    output logic                      out
);

    always_comb begin
        case (sel)
            `CSS_CODE_TRIP_ONE:   out = src.trip[0];
            `CSS_CODE_TRIP_TWO:   out = src.trip[1];
            `CSS_CODE_TRIP_THREE: out = src.trip[2];
            `CSS_CODE_COMP_ONE:   out = src.comp[0];
            `CSS_CODE_COMP_TWO:   out = src.comp[1];
            `CSS_CODE_COMP_THREE: out = src.comp[2];
            // Reserved codes give a quiet low input
            default:              out = 1'b0;
        endcase
    end

endmodule : source_mux

// ==== dv/source_model.sv ====
`timescale 1ns/1ps

module source_model (
    // Clock
    input  wire logic       ref_clk,
    // Next levels from the bench
    input  wire logic [5:0] pattern,
    // Trip and comparator levels
    output logic            trip_input_one,
    output logic            trip_input_two,
    output logic            trip_input_three,
    output logic            comparator_one_output,
    output logic            comparator_two_output,
    output logic            comparator_three_output
);
    // Plain levels, changing right after an edge; short pulses test for latching
    always @(posedge ref_clk) begin
        {comparator_three_output, comparator_two_output, comparator_one_output,
         trip_input_three, trip_input_two, trip_input_one} <= pattern;
    end
endmodule : source_model

// ==== dv/compare_input_source_select_tb_top.sv ====
`timescale 1ns/1ps

module compare_input_source_select_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0;
    logic [7:0] st = 8'h00;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [5:0] pat = 6'h00;
    logic t1, t2, t3, c1, c2, c3;
    cmp_sel_pkg::compare_inputs_t ci, exp_q = 4'h0;
    cmp_sel_pkg::events_t ev, exp_ev = 4'h0;
    logic [15:0] sel_m = 16'h0000;
    logic [11:0] qual_m = 12'h000;
    logic chk = 1'b0;
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA};
    integer seed = 23288;
    int n_fail = 0, n_compared = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #5 ref_clk = ~ref_clk;

    compare_input_source_select u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .trip_input_one(t1), .trip_input_two(t2), .trip_input_three(t3),
        .comparator_one_output(c1), .comparator_two_output(c2),
        .comparator_three_output(c3), .compare_inputs(ci), .compare_events(ev));

    source_model u_src (
        .ref_clk(ref_clk), .pattern(pat), .trip_input_one(t1), .trip_input_two(t2),
        .trip_input_three(t3), .comparator_one_output(c1),
        .comparator_two_output(c2), .comparator_three_output(c3));

    function automatic logic pick(input logic [3:0] c, input logic [5:0] s);
        case (c)
            4'h0: pick = s[0];
            4'h1: pick = s[1];
            4'h2: pick = s[2];
            4'h8: pick = s[3];
            4'h9: pick = s[4];
            4'hA: pick = s[5];
            default: pick = 1'b0;
        endcase
    endfunction : pick

    function automatic logic qual(input logic [2:0] q, input logic hi, input logic lo);
        case (q)
            3'h1: qual = !hi;
            3'h2: qual = hi;
            3'h3: qual = !lo;
            3'h4: qual = lo;
            3'h5: qual = lo && !hi;
            default: qual = 1'b0;
        endcase
    endfunction : qual

    task automatic final_report;
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Model runs on every edge; outputs compared while no write is changing config
    always @(posedge ref_clk) begin
        logic [5:0] s;
        s = {c3, c2, c1, t3, t2, t1};
        pat <= 6'($random(seed));
        if (chk) cmp({24'h0, ev, ci}, {24'h0, exp_ev, exp_q});
        exp_q <= {pick(sel_m[15:12], s), pick(sel_m[11:8], s),
                  pick(sel_m[7:4], s), pick(sel_m[3:0], s)};
        exp_ev <= {qual(qual_m[11:9], exp_q.b_high, exp_q.b_low),
                   qual(qual_m[8:6], exp_q.b_high, exp_q.b_low),
                   qual(qual_m[5:3], exp_q.a_high, exp_q.a_low),
                   qual(qual_m[2:0], exp_q.a_high, exp_q.a_low)};
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        chk <= 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            // Late bready makes the slave hold its response
            if (i == 2) bready <= 1'b1;
        end
        if (i == 50) begin
            n_fail++;
            final_report();
        end
        r = bresp;
        bready <= 1'b0;
        if (a == 8'h00) sel_m <= v[15:0];
        if (a == 8'h04) qual_m <= v[11:0];
        repeat (3) @(posedge ref_clk);
        chk <= 1'b1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                st = {exp_ev, exp_q};
            end
            if (rvalid) break;
        end
        if (i == 50) begin
            n_fail++;
            final_report();
        end
        d = rdata;
        r = rresp;
    endtask : rd

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk <= 1'b1;
        rd(8'h00);
        cmp(d, 32'h0);
        rd(8'h04);
        cmp(d, 32'h0);
        repeat (20) @(posedge ref_clk);
        // Each field walks all six codes, fields offset so they differ
        for (int k = 0; k < 6; k++) begin
            d = {16'h0, codes[(k + 3) % 6], codes[(k + 2) % 6],
                 codes[(k + 1) % 6], codes[k]};
            wr(8'h00, d);
            cmp({30'h0, r}, 32'h0);
            rd(8'h00);
            cmp(d, {16'h0, codes[(k + 3) % 6], codes[(k + 2) % 6],
                    codes[(k + 1) % 6], codes[k]});
            repeat (20) @(posedge ref_clk);
        end
        // Reserved codes drive their compare input low
        wr(8'h00, 32'h0000F3B7);
        rd(8'h00);
        cmp(d, 32'h0000F3B7);
        repeat (20) @(posedge ref_clk);
        // Every event code, including reserved ones, on all four events
        wr(8'h00, 32'h00009821);
        for (int q = 0; q < 8; q++) begin
            wr(8'h04, {20'h0, 3'(q), 3'(q), 3'(q), 3'(q)});
            rd(8'h04);
            cmp(d, {20'h0, 3'(q), 3'(q), 3'(q), 3'(q)});
            rd(8'h08);
            cmp({d[29:0], r}, {22'h0, st, 2'h0});
            repeat (30) @(posedge ref_clk);
        end
        // Unmapped and read-only places refuse
        wr(8'h0C, 32'h0000FFFF);
        cmp({30'h0, r}, 32'h2);
        wr(8'h08, 32'h0000FFFF);
        cmp({30'h0, r}, 32'h2);
        rd(8'h0C);
        cmp({d[29:0], r}, 32'h2);
        rd(8'h00);
        cmp(d, 32'h00009821);
        final_report();
    end
endmodule : compare_input_source_select_tb_top
